// *** rtl/bscan_pkg.sv ***
// constants and types shared by the boundary-scan test port
package bscan_pkg;
  localparam int IR_LEN = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_HIGHZ = 4'h3;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // arbitrary identity value, bit 0 set as the standard demands
  localparam logic [31:0] IDCODE_DEFAULT = 32'h0a5c_0001;
  localparam int ID_LEN = 32;
  localparam int SYNC_DEPTH = 3;
  localparam int TMS_RESET_CLOCKS = 5;
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IDCODE = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TMS_PU_BIT = 1;
  localparam int CTRL_TDI_PU_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  localparam int ST_TLR_BIT = 0;
  localparam int ST_EXTEST_BIT = 1;
  localparam int ST_HIGHZ_BIT = 2;
  localparam int ST_EN_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
    SH_DR = 4'h6, EX1_DR = 4'h7, PA_DR = 4'h5, EX2_DR = 4'h4,
    UPD_DR = 4'hc, SEL_IR = 4'hd, CAP_IR = 4'hf, SH_IR = 4'he,
    EX1_IR = 4'ha, PA_IR = 4'hb, EX2_IR = 4'h9, UPD_IR = 4'h8
  } tap_state_t;
endpackage

// *** rtl/boundary_scan_test_port.sv ***
// boundary-scan test port: tap controller, scan cells, AXI4-Lite control
`timescale 1ns/10ps
module boundary_scan_test_port #(
  parameter int N_IO = 32,
  parameter int N_IN = 4,
  parameter int N_MC = 32,
  parameter logic [31:0] IDCODE_VALUE = bscan_pkg::IDCODE_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [bscan_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [bscan_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tck,
  input wire logic tms_i,
  output logic tms_o,
  output logic tms_oe,
  input wire logic tdi_i,
  output logic tdi_o,
  output logic tdi_oe,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic user_tms_o,
  input wire logic user_tms_oe,
  input wire logic user_tdi_o,
  input wire logic user_tdi_oe,
  input wire logic user_tdo_o,
  input wire logic user_tdo_oe,
  output logic tms_pullup_en,
  output logic tdi_pullup_en,
  input wire logic [N_IN-1:0] in_pin_i,
  input wire logic [N_IO-1:0] io_i,
  output logic [N_IO-1:0] io_o,
  output logic [N_IO-1:0] io_oe,
  input wire logic [N_IO-1:0] core_out,
  input wire logic [N_IO-1:0] core_oe,
  input wire logic [N_MC-1:0] mc_fb
);
  localparam int IO_IN_LO = N_IN;
  localparam int IO_OUT_LO = N_IN + N_IO;
  localparam int IO_OE_LO = N_IN + 2 * N_IO;
  localparam int MC_LO = N_IN + 3 * N_IO;
  localparam int BSR_LEN = N_IN + 3 * N_IO + N_MC;
  localparam int CW = BSR_LEN + 2;

  if (N_IO < 1 || N_IO > 32 || N_IN < 1 || N_IN > 4 || N_MC < 1 || N_MC > 32) begin
    $error("pin or logic-cell count out of range");
  end

  function automatic logic [CW-1:0] settle(input logic [CW-1:0] s2, input logic [CW-1:0] s3,
                                          input logic [CW-1:0] held);
    return (s3 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
  endfunction

  // ---------------- register side (aclk) ----------------
  logic [2:0] ctrl_q;
  logic [bscan_pkg::AXI_AW-1:0] aw_addr_q;
  logic aw_full_q, w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [3:0] st_s1_q, st_s2_q, st_s3_q, st_q;
  logic tlr_flag_q, extest_flag_q, highz_flag_q;
  logic tap_req_q;
  logic [2:0] ack_s_q;

  assign awready = !aw_full_q && !bvalid;
  assign wready = !w_full_q && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (aw_full_q && w_full_q) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (aw_full_q && w_full_q) begin
      w_full_q <= 1'b0;
    end
  end

  // write answer follows both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= bscan_pkg::RESP_OKAY;
      ctrl_q <= bscan_pkg::CTRL_RESET;
    end else if (aw_full_q && w_full_q) begin
      bvalid <= 1'b1;
      if (aw_addr_q == bscan_pkg::REG_CTRL) begin
        bresp <= bscan_pkg::RESP_OKAY;
        if (w_strb_q[0]) begin
          ctrl_q <= w_data_q[2:0];
        end
      end else if (aw_addr_q == bscan_pkg::REG_STATUS || aw_addr_q == bscan_pkg::REG_IDCODE) begin
        bresp <= bscan_pkg::RESP_OKAY;
      end else begin
        bresp <= bscan_pkg::RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= bscan_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= bscan_pkg::RESP_OKAY;
      unique case (araddr)
        bscan_pkg::REG_CTRL: rdata <= {29'h0, ctrl_q};
        bscan_pkg::REG_STATUS: rdata <= {28'h0, st_q};
        bscan_pkg::REG_IDCODE: rdata <= IDCODE_VALUE;
        default: begin
          rdata <= '0;
          rresp <= bscan_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // status levels: three flags from the test clock domain plus the enable bit of ctrl_q
  always_ff @(posedge aclk) begin
    st_s1_q <= {ctrl_q[bscan_pkg::CTRL_EN_BIT], highz_flag_q, extest_flag_q, tlr_flag_q};
    st_s2_q <= st_s1_q;
    st_s3_q <= st_s2_q;
    st_q <= (st_s3_q & ~(st_s2_q ^ st_s3_q)) | (st_q & (st_s2_q ^ st_s3_q));
  end

  // shared test pins fall back to user I/O when the port is off
  always_comb begin
    tms_pullup_en = ctrl_q[bscan_pkg::CTRL_TMS_PU_BIT];
    tdi_pullup_en = ctrl_q[bscan_pkg::CTRL_TDI_PU_BIT];
    tms_o = user_tms_o;
    tdi_o = user_tdi_o;
    tms_oe = !ctrl_q[bscan_pkg::CTRL_EN_BIT] && user_tms_oe;
    tdi_oe = !ctrl_q[bscan_pkg::CTRL_EN_BIT] && user_tdi_oe;
  end

  // ---------------- link side (tck) ----------------
  logic [CW-1:0] sy1_q, sy2_q, sy3_q, stab_q;
  logic tap_rst;
  bscan_pkg::tap_state_t state_q, state_d;
  logic [bscan_pkg::IR_LEN-1:0] ir_q, ir_sh_q;
  logic [bscan_pkg::ID_LEN-1:0] id_q;
  logic byp_q;
  logic [BSR_LEN-1:0] bsr_q;
  logic [N_IO-1:0] out_upd_q, oe_upd_q;
  logic tdo_q, tdo_en_q;
  logic sel_bsr, sel_id;

  // power-on and option level, plus live signals for capture
  always_ff @(posedge tck) begin
    sy1_q <= {!tap_req_q, ctrl_q[bscan_pkg::CTRL_EN_BIT], mc_fb, core_oe, core_out, io_i, in_pin_i};
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    stab_q <= settle(sy2_q, sy3_q, stab_q);
  end
  assign tap_rst = !(stab_q[CW-1] && stab_q[CW-2]);

  // power-on request held until the test clock side has seen it
  always_ff @(posedge aclk) begin
    ack_s_q <= {ack_s_q[1:0], !stab_q[CW-1]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_req_q <= 1'b1;
    end else if (ack_s_q[2] && ack_s_q[1]) begin
      tap_req_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (state_q)
      bscan_pkg::TLR: state_d = tms_i ? bscan_pkg::TLR : bscan_pkg::RTI;
      bscan_pkg::RTI: state_d = tms_i ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
      bscan_pkg::SEL_DR: state_d = tms_i ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
      bscan_pkg::CAP_DR: state_d = tms_i ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::SH_DR: state_d = tms_i ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::EX1_DR: state_d = tms_i ? bscan_pkg::UPD_DR : bscan_pkg::PA_DR;
      bscan_pkg::PA_DR: state_d = tms_i ? bscan_pkg::EX2_DR : bscan_pkg::PA_DR;
      bscan_pkg::EX2_DR: state_d = tms_i ? bscan_pkg::UPD_DR : bscan_pkg::SH_DR;
      bscan_pkg::UPD_DR: state_d = tms_i ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
      bscan_pkg::SEL_IR: state_d = tms_i ? bscan_pkg::TLR : bscan_pkg::CAP_IR;
      bscan_pkg::CAP_IR: state_d = tms_i ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::SH_IR: state_d = tms_i ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::EX1_IR: state_d = tms_i ? bscan_pkg::UPD_IR : bscan_pkg::PA_IR;
      bscan_pkg::PA_IR: state_d = tms_i ? bscan_pkg::EX2_IR : bscan_pkg::PA_IR;
      bscan_pkg::EX2_IR: state_d = tms_i ? bscan_pkg::UPD_IR : bscan_pkg::SH_IR;
      bscan_pkg::UPD_IR: state_d = tms_i ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      state_q <= bscan_pkg::TLR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || state_q == bscan_pkg::TLR) begin
      ir_sh_q <= '0;
      ir_q <= bscan_pkg::OP_IDCODE;
    end else if (state_q == bscan_pkg::CAP_IR) begin
      ir_sh_q <= bscan_pkg::IR_CAPTURE;
    end else if (state_q == bscan_pkg::SH_IR) begin
      ir_sh_q <= {tdi_i, ir_sh_q[bscan_pkg::IR_LEN-1:1]};
    end else if (state_q == bscan_pkg::UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // unknown opcodes fall through to bypass
  assign sel_bsr = ir_q == bscan_pkg::OP_EXTEST || ir_q == bscan_pkg::OP_SAMPLE;
  assign sel_id = ir_q == bscan_pkg::OP_IDCODE;

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      byp_q <= 1'b0;
      id_q <= '0;
    end else if (state_q == bscan_pkg::CAP_DR) begin
      byp_q <= 1'b0;
      id_q <= IDCODE_VALUE;
    end else if (state_q == bscan_pkg::SH_DR) begin
      byp_q <= tdi_i;
      id_q <= {tdi_i, id_q[bscan_pkg::ID_LEN-1:1]};
    end
  end

  // chain: inputs, pin inputs, pin outputs, pin enables, logic cells
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      bsr_q <= '0;
    end else if (state_q == bscan_pkg::CAP_DR && sel_bsr) begin
      bsr_q <= stab_q[BSR_LEN-1:0];
    end else if (state_q == bscan_pkg::SH_DR && sel_bsr) begin
      bsr_q <= {tdi_i, bsr_q[BSR_LEN-1:1]};
    end
  end

  // two update stages per I/O cell
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      out_upd_q <= '0;
      oe_upd_q <= '0;
    end else if (state_q == bscan_pkg::UPD_DR && sel_bsr) begin
      out_upd_q <= bsr_q[IO_OE_LO-1:IO_OUT_LO];
      oe_upd_q <= bsr_q[MC_LO-1:IO_OE_LO];
    end
  end

  // serial output changes on the falling edge
  always_ff @(negedge tck) begin
    if (tap_rst) begin
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_en_q <= state_q == bscan_pkg::SH_DR || state_q == bscan_pkg::SH_IR;
      if (state_q == bscan_pkg::SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (state_q == bscan_pkg::SH_DR) begin
        tdo_q <= sel_bsr ? bsr_q[0] : sel_id ? id_q[0] : byp_q;
      end
    end
  end

  always_ff @(posedge tck) begin
    tlr_flag_q <= state_q == bscan_pkg::TLR;
    extest_flag_q <= !tap_rst && ir_q == bscan_pkg::OP_EXTEST;
    highz_flag_q <= !tap_rst && ir_q == bscan_pkg::OP_HIGHZ;
  end

  always_comb begin
    tdo_o = ctrl_q[bscan_pkg::CTRL_EN_BIT] ? tdo_q : user_tdo_o;
    tdo_oe = ctrl_q[bscan_pkg::CTRL_EN_BIT] ? tdo_en_q : user_tdo_oe;
    io_o = extest_flag_q ? out_upd_q : core_out;
    io_oe = highz_flag_q ? '0 : extest_flag_q ? oe_upd_q : core_oe;
  end

  // ---------------- checks ----------------
  sequence tms_high_five_s;
    tms_i [*5];
  endsequence

  por_reset_tap_a: assert property (
    @(posedge tck) disable iff (1'b0) tap_rst |=> state_q == bscan_pkg::TLR)
    else $error("tap not in reset after power-on level");

  tms_five_reset_a: assert property (
    @(posedge tck) disable iff (tap_rst) tms_high_five_s |=> state_q == bscan_pkg::TLR)
    else $error("five high mode bits did not reach reset");

  ir_reset_idcode_a: assert property (
    @(posedge tck) disable iff (tap_rst) state_q == bscan_pkg::TLR |=> ir_q == bscan_pkg::OP_IDCODE)
    else $error("instruction not idcode after reset");

  bsr_capture_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_q == bscan_pkg::CAP_DR && sel_bsr |=> bsr_q == $past(stab_q[BSR_LEN-1:0]))
    else $error("chain did not capture live signals");

  bsr_shift_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_q == bscan_pkg::SH_DR && sel_bsr |=> bsr_q[BSR_LEN-1] == $past(tdi_i)
      && bsr_q[BSR_LEN-2:0] == $past(bsr_q[BSR_LEN-1:1]))
    else $error("chain did not shift from data input");

  update_load_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_q == bscan_pkg::UPD_DR && sel_bsr |=> out_upd_q == $past(bsr_q[IO_OE_LO-1:IO_OUT_LO])
      && oe_upd_q == $past(bsr_q[MC_LO-1:IO_OE_LO]))
    else $error("update stages not loaded");

  bypass_one_bit_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_q == bscan_pkg::SH_DR && ir_q == bscan_pkg::OP_BYPASS |=> byp_q == $past(tdi_i))
    else $error("bypass not one stage");

  highz_pins_a: assert property (
    @(posedge tck) disable iff (tap_rst) highz_flag_q |-> io_oe == '0)
    else $error("pins driven under highz");

  disabled_pins_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_q[bscan_pkg::CTRL_EN_BIT] |-> tdo_oe == user_tdo_oe && tms_oe == user_tms_oe)
    else $error("test pins not handed to user");

  pullup_option_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aw_full_q && w_full_q && aw_addr_q == bscan_pkg::REG_CTRL && w_strb_q[0]
      |=> tdi_pullup_en == $past(w_data_q[bscan_pkg::CTRL_TDI_PU_BIT]))
    else $error("pull-up option not applied");
endmodule

// *** tb/jtag_ctrl_model.sv ***
// partner model: external test and programming controller on the four test pins
`timescale 1ns/10ps
module jtag_ctrl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock, pins move while tck low, tdo read at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo;
    #62.5 tck = 1'b0;
  endtask
  // five clocks with mode high reach the reset state, no reset pin needed
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
  endtask
  // ir or dr scan from idle, lsb first, back to idle after update
  task automatic scan(input logic ir, input int n, input logic [131:0] din,
                      output logic [131:0] dout);
    logic q;
    dout = '0;
    step(1'b0, ~tdi, q);
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// *** tb/tb_top.sv ***
// testbench top: bus master, pin wiring and scenarios for the test port
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, in_pin = 4'ha;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, io_i = 32'h1234_5678, core_out = 32'hcafe_0f0f;
  logic [31:0] core_oe = 32'h00ff_ff00, mc_fb = 32'h8421_7e81;
  logic [31:0] pre_out = 32'h5a5a_a5a5, pre_oe = 32'hf0f0_0f0f;
  logic u_tms_o = 1'b1, u_tms_oe = 1'b1, u_tdi_o = 1'b0, u_tdi_oe = 1'b1;
  logic u_tdo_o = 1'b0, u_tdo_oe = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, tck, m_tms, m_tdi;
  logic tms_o, tms_oe, tdi_o, tdi_oe, tdo_o, tdo_oe, tms_pu, tdi_pu;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, io_o, io_oe, d;
  logic [131:0] q;
  int checked = 0;
  int n_mismatch = 0;
  wire tms_pin = tms_oe ? tms_o : m_tms;
  wire tdi_pin = tdi_oe ? tdi_o : m_tdi;
  wire tdo_pin = tdo_oe ? tdo_o : ~tdo_o;
  always #5 aclk = ~aclk;
  jtag_ctrl_model i_jtag_ctrl_model (.tck(tck), .tms(m_tms), .tdi(m_tdi), .tdo(tdo_pin));
  boundary_scan_test_port i_boundary_scan_test_port (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tck(tck), .tms_i(tms_pin), .tms_o(tms_o), .tms_oe(tms_oe), .tdi_i(tdi_pin),
    .tdi_o(tdi_o), .tdi_oe(tdi_oe), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .user_tms_o(u_tms_o), .user_tms_oe(u_tms_oe), .user_tdi_o(u_tdi_o),
    .user_tdi_oe(u_tdi_oe), .user_tdo_o(u_tdo_o), .user_tdo_oe(u_tdo_oe),
    .tms_pullup_en(tms_pu), .tdi_pullup_en(tdi_pu), .in_pin_i(in_pin), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe), .core_out(core_out), .core_oe(core_oe), .mc_fb(mc_fb)
  );
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'bxx;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 2'bxx;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    axi_read(a);
    `CHK(d & m, e)
    `CHK(r, er)
  endtask
  task automatic status_chk(input logic [31:0] e);
    repeat (10) @(posedge aclk);
    rd_chk(bscan_pkg::REG_STATUS, 32'hf, e, bscan_pkg::RESP_OKAY);
  endtask
  task automatic ir_load(input logic [3:0] op);
    i_jtag_ctrl_model.scan(1'b1, 4, {128'h0, op}, q);
    `CHK(q[3:0], bscan_pkg::IR_CAPTURE)
    i_jtag_ctrl_model.step(1'b0, 1'b0, q[0]);
  endtask
  task automatic dr_bypass();
    i_jtag_ctrl_model.scan(1'b0, 2, 132'h1, q);
    `CHK(q[1:0], 2'b10)
  endtask
  task automatic t_reset();
    rd_chk(bscan_pkg::REG_CTRL, 32'h7, 32'h7, bscan_pkg::RESP_OKAY);
    `CHK({tms_pu, tdi_pu}, 2'b11)
    status_chk(32'h9);
    rd_chk(bscan_pkg::REG_IDCODE, '1, bscan_pkg::IDCODE_DEFAULT, bscan_pkg::RESP_OKAY);
    axi_write(bscan_pkg::REG_IDCODE, 32'h0);
    `CHK(r, bscan_pkg::RESP_OKAY)
    rd_chk(bscan_pkg::REG_IDCODE, '1, bscan_pkg::IDCODE_DEFAULT, bscan_pkg::RESP_OKAY);
    rd_chk(4'hc, '1, 32'h0, bscan_pkg::RESP_SLVERR);
    i_jtag_ctrl_model.scan(1'b0, 32, 132'h0, q);
    `CHK(q[31:0], bscan_pkg::IDCODE_DEFAULT)
  endtask
  task automatic t_sample_extest();
    ir_load(bscan_pkg::OP_SAMPLE);
    i_jtag_ctrl_model.scan(1'b0, 132, {32'h0, pre_oe, pre_out, 36'h0}, q);
    `CHK(q, {mc_fb, core_oe, core_out, io_i, in_pin})
    `CHK(q[131:100], mc_fb)
    `CHK(io_o, core_out)
    ir_load(bscan_pkg::OP_EXTEST);
    `CHK(io_o, pre_out)
    `CHK(io_oe, pre_oe)
    status_chk(32'ha);
  endtask
  task automatic t_highz_bypass();
    ir_load(bscan_pkg::OP_HIGHZ);
    `CHK(io_oe, 32'h0)
    status_chk(32'hc);
    ir_load(4'h5);
    dr_bypass();
    ir_load(bscan_pkg::OP_BYPASS);
    dr_bypass();
    `CHK(io_o, core_out)
    `CHK(io_oe, core_oe)
  endtask
  task automatic t_option();
    `CHK({tms_oe, tdi_oe, tdo_oe}, 3'b000)
    axi_write(bscan_pkg::REG_CTRL, 32'h6);
    `CHK(r, bscan_pkg::RESP_OKAY)
    i_jtag_ctrl_model.reset5();
    `CHK({tms_oe, tms_o, tdi_oe, tdi_o, tdo_oe, tdo_o}, 6'h3a)
    status_chk(32'h1);
    axi_write(bscan_pkg::REG_CTRL, 32'h1);
    `CHK({tms_pu, tdi_pu}, 2'b00)
    i_jtag_ctrl_model.reset5();
    status_chk(32'h9);
    i_jtag_ctrl_model.scan(1'b0, 32, 132'h0, q);
    `CHK(q[31:0], bscan_pkg::IDCODE_DEFAULT)
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    i_jtag_ctrl_model.reset5();
    i_jtag_ctrl_model.reset5();
    t_reset();
    t_sample_extest();
    t_highz_bypass();
    t_option();
    finish_test();
  end
endmodule
